// >>> encoder_irq_consts.vh
// constants for the encoder interrupt clear, force and status block
`ifndef ENCODER_IRQ_CONSTS_VH
`define ENCODER_IRQ_CONSTS_VH

// bus geometry
`define AXI_ADDR_W         8
`define AXI_DATA_W         32
`define REG_W              16

// register byte offsets
`define OFF_IRQ_FLAG       8'h00
`define OFF_IRQ_CLEAR      8'h04
`define OFF_IRQ_FORCE      8'h08
`define OFF_ENC_STATUS     8'h0C

// interrupt flag, clear and force bit positions
`define BIT_GLOBAL_INT     0
`define BIT_EVT_LO         1
`define BIT_EVT_HI         11
`define EVT_W              11

// status bit positions
`define STS_COUNT_ERR      0
`define STS_STICKY_LO      1
`define STS_STICKY_HI      3
`define STS_IDX_LATCH_DIR  4
`define STS_CUR_DIR        5
`define STS_FIRST_IDX_DIR  6
`define STS_UNIT_POS       7

// reset values
`define RST_EVT_FLAGS      11'h000
`define RST_FORCE          11'h000
`define RST_STICKY         3'h7
`define RST_COUNT_ERR      1'b0
`define RST_GLOBAL_INT     1'b0

// response codes
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> sticky_bits.v
// vector of sticky flags: hardware set wins over software clear
module sticky_bits #(
  parameter WIDTH = 11
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] rst_val,
  input  wire [WIDTH-1:0] set_bits,
  input  wire [WIDTH-1:0] clr_bits,
  output wire [WIDTH-1:0] flags
);

  reg [WIDTH-1:0] flag_reg;   // held flags

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // one flag: set beats clear in the same cycle
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          flag_reg[i] <= rst_val[i];
        end else if (set_bits[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (clr_bits[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flag_reg;

endmodule // sticky_bits

// >>> axi_lite_port.v
// axi4-lite slave handshake front end, one write and one read at a time
`include "encoder_irq_consts.vh"
module axi_lite_port (
  input  wire                   clk_sys,
  input  wire                   rst_n,
  input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  input  wire [`AXI_DATA_W-1:0] s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  output reg  [`AXI_DATA_W-1:0] s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  output wire                   wr_fire,
  output reg  [`AXI_ADDR_W-1:0] wr_addr,
  output reg  [`AXI_DATA_W-1:0] wr_data,
  output reg  [3:0]             wr_strb,
  input  wire                   wr_err,
  output wire                   rd_fire,
  output reg  [`AXI_ADDR_W-1:0] rd_addr,
  input  wire [`AXI_DATA_W-1:0] rd_data,
  input  wire                   rd_err
);

  reg aw_held;   // write address captured
  reg w_held;    // write data captured
  reg ar_held;   // read address captured

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign rd_fire = ar_held & ~s_axi_rvalid;

  // write channels: take address and data in any order, answer after both
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= {`AXI_ADDR_W{1'b0}};
      wr_data       <= {`AXI_DATA_W{1'b0}};
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: data registered one cycle after the address is held
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= {`AXI_DATA_W{1'b0}};
      ar_held       <= 1'b0;
      rd_addr       <= {`AXI_ADDR_W{1'b0}};
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_held       <= 1'b1;
        rd_addr       <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (rd_fire) begin
        ar_held      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // axi_lite_port

// >>> encoder_irq_clear_force_status.v
// encoder interrupt flag, clear, force and status registers behind axi4-lite
// usage notes
// flag word ignores writes
// clear word reads as zero
// unmapped words answer slverr
// hardware set beats software clear
// rearm leaves global low one cycle
// status levels lag one cycle
// force writes pulse, never hold
// irq_enable comes from outside
`include "encoder_irq_consts.vh"
module encoder_irq_clear_force_status (
  input  wire                   clk_sys,
  input  wire                   rst_n,

  // register bus
  // write address, data, response
  input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [`AXI_DATA_W-1:0] s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  // read address and data
  input  wire [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [`AXI_DATA_W-1:0] s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready,

  // event pulses from the encoder units
  input  wire                   unit_timeout_evt,
  input  wire                   index_latch_evt,
  input  wire                   strobe_latch_evt,
  input  wire                   compare_match_evt,
  input  wire                   compare_ready_evt,
  input  wire                   count_overflow_evt,
  input  wire                   count_underflow_evt,
  input  wire                   watchdog_expiry_evt,
  input  wire                   direction_change_evt,
  input  wire                   phase_error_evt,
  input  wire                   count_error_evt,

  // per-event interrupt enables, bit 0 unused
  input  wire [`REG_W-1:0]      irq_enable,

  // status sources
  // direction and unit levels
  input  wire                   unit_position_seen,
  input  wire                   first_index_direction,
  input  wire                   current_direction,
  input  wire                   index_latched_direction,
  // sticky and index pulses
  input  wire                   capture_overflow_pulse,
  input  wire                   capture_direction_pulse,
  input  wire                   first_index_pulse,
  input  wire                   index_event_pulse,
  input  wire                   index_count_error,

  // interrupt request to the system
  output reg                    irq_req,
  output reg                    irq_active
);

  // bus front-end strobes
  wire                   wr_fire;      // one-cycle write commit
  wire [`AXI_ADDR_W-1:0] wr_addr;      // held write address
  wire [`AXI_DATA_W-1:0] wr_data;      // held write data
  wire [3:0]             wr_strb;      // held byte strobes

  wire                   rd_fire;      // one-cycle read commit
  wire [`AXI_ADDR_W-1:0] rd_addr;      // held read address
  reg  [`AXI_DATA_W-1:0] rd_data;      // read mux result
  wire                   wr_err;       // write to unmapped word
  wire                   rd_err;       // read from unmapped word

  // register state
  reg  [`EVT_W-1:0]      force_reg;    // stored force pattern
  reg  [`EVT_W-1:0]      force_next;

  reg                    int_reg;      // global interrupt flag
  reg                    int_next;

  reg                    count_err_reg;  // counter error status
  reg                    count_err_next;

  reg  [3:0]             dir_sts_reg;  // registered direction/unit bits
  wire [`EVT_W-1:0]      evt_flags;    // per-event flags 11..1
  wire [2:0]             sticky_sts;   // capture/index sticky bits

  // decoded write data
  wire [`REG_W-1:0]      wr_masked;    // strobe-masked low half

  wire                   wr_clear;     // write hits clear register
  wire                   wr_force;     // write hits force register
  wire                   wr_status;    // write hits status register

  wire [`EVT_W-1:0]      evt_in;       // incoming event pulses
  wire [`EVT_W-1:0]      evt_force;    // events forced by software
  wire [`EVT_W-1:0]      evt_clear;    // flags cleared by software

  wire [2:0]             sticky_clr;   // status bits cleared by software
  wire [2:0]             sticky_set;   // status bits set by hardware

  wire                   pending;      // enabled flag outstanding
  wire [`REG_W-1:0]      flag_word;    // flag register image
  wire [`REG_W-1:0]      force_word;   // force register image
  wire [`REG_W-1:0]      status_word;  // status register image

  // word index is addr[7:2]
  // true when an address selects the given register word
  function addr_is;
    input [`AXI_ADDR_W-1:0] addr;
    input [`AXI_ADDR_W-1:0] off;
    begin
      addr_is = (addr[`AXI_ADDR_W-1:2] == off[`AXI_ADDR_W-1:2]);
    end
  endfunction

  // true when an address selects any mapped word
  function addr_mapped;
    input [`AXI_ADDR_W-1:0] addr;
    begin
      addr_mapped = addr_is(addr, `OFF_IRQ_FLAG) | addr_is(addr, `OFF_IRQ_CLEAR) |
                    addr_is(addr, `OFF_IRQ_FORCE) | addr_is(addr, `OFF_ENC_STATUS);
    end
  endfunction

  // lanes 2 and 3 are dropped
  // keeps only the bytes whose strobe is set, low 16 bits
  function [`REG_W-1:0] lane_mask;
    input [`AXI_DATA_W-1:0] data;
    input [3:0]             strb;
    begin
      lane_mask = {data[15:8] & {8{strb[1]}}, data[7:0] & {8{strb[0]}}};
    end
  endfunction

  // bus slave handshake
  // one write, one read in flight
  axi_lite_port u_bus (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_fire       (wr_fire),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_fire       (rd_fire),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // unmapped words answer with a slave error
  assign wr_err = ~addr_mapped(wr_addr);
  assign rd_err = ~addr_mapped(rd_addr);

  // write decode
  // uses the held address, stable
  // for the whole commit cycle
  assign wr_masked = lane_mask(wr_data, wr_strb);
  assign wr_clear  = wr_fire & addr_is(wr_addr, `OFF_IRQ_CLEAR);
  assign wr_force  = wr_fire & addr_is(wr_addr, `OFF_IRQ_FORCE);
  assign wr_status = wr_fire & addr_is(wr_addr, `OFF_ENC_STATUS);

  // event pulses packed at their flag positions 11 down to 1
  assign evt_in = {unit_timeout_evt,     // bit 11
                   index_latch_evt,      // bit 10
                   strobe_latch_evt,     // bit 9
                   compare_match_evt,    // bit 8
                   compare_ready_evt,    // bit 7
                   count_overflow_evt,   // bit 6
                   count_underflow_evt,  // bit 5
                   watchdog_expiry_evt,  // bit 4
                   direction_change_evt, // bit 3
                   phase_error_evt,      // bit 2
                   count_error_evt};     // bit 1

  // a one in a force bit raises that event, a zero does nothing
  assign evt_force = wr_force ? wr_masked[`BIT_EVT_HI:`BIT_EVT_LO] : {`EVT_W{1'b0}};

  // a one in a clear bit drops that flag, a zero keeps it
  assign evt_clear = wr_clear ? wr_masked[`BIT_EVT_HI:`BIT_EVT_LO] : {`EVT_W{1'b0}};

  // per-event flags; a hardware or forced set wins over a clear
  // events and forces share set side
  sticky_bits #(
    .WIDTH (`EVT_W)
  ) u_evt_flags (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .rst_val  (`RST_EVT_FLAGS),
    .set_bits (evt_in | evt_force),
    .clr_bits (evt_clear),
    .flags    (evt_flags)
  );

  // any enabled flag outstanding
  // enable bit 0 is unused
  assign pending = |(evt_flags & irq_enable[`BIT_EVT_HI:`BIT_EVT_LO]);

  // global flag: raised by a pending flag only while low, held until cleared
  // a bit 0 clear while low is moot;
  // a pending flag then wins
  always @* begin
    int_next = int_reg;
    if (!int_reg) begin
      int_next = pending;
    end else if (wr_clear && wr_masked[`BIT_GLOBAL_INT]) begin
      int_next = 1'b0;
    end
  end

  // global flag and request pulse registers
  // irq_req marks the rising cycle
  // irq_active mirrors the stored flag
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      int_reg    <= `RST_GLOBAL_INT;
      irq_req    <= 1'b0;
      irq_active <= 1'b0;
    end else begin
      int_reg    <= int_next;
      irq_req    <= ~int_reg & int_next;
      irq_active <= int_next;
    end
  end

  // force register keeps the last written per-event pattern
  // readback only; pulse is evt_force
  always @* begin
    force_next = force_reg;
    if (wr_force) begin
      force_next = wr_masked[`BIT_EVT_HI:`BIT_EVT_LO];
    end
  end

  // force register storage
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      force_reg <= `RST_FORCE;
    end else begin
      force_reg <= force_next;
    end
  end

  // capture overflow, capture direction and first index are sticky
  assign sticky_set = {capture_overflow_pulse, capture_direction_pulse, first_index_pulse};
  assign sticky_clr = wr_status ? wr_masked[`STS_STICKY_HI:`STS_STICKY_LO] : 3'h0;

  // status sticky bits, set wins over a write-one clear
  // reset to ones; software clears
  sticky_bits #(
    .WIDTH (3)
  ) u_sts_sticky (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .rst_val  (`RST_STICKY),
    .set_bits (sticky_set),
    .clr_bits (sticky_clr),
    .flags    (sticky_sts)
  );

  // counter error status follows the last index transition only
  // error level read only at index
  always @* begin
    count_err_next = count_err_reg;
    if (index_event_pulse) begin
      count_err_next = index_count_error;
    end
  end

  // counter error status and direction bits registers
  // levels registered for the mux
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      count_err_reg <= `RST_COUNT_ERR;
      dir_sts_reg   <= 4'h0;
    end else begin
      count_err_reg <= count_err_next;
      dir_sts_reg   <= {unit_position_seen, first_index_direction,
                        current_direction, index_latched_direction};
    end
  end

  // register images, reserved bits zero
  assign flag_word   = {4'h0, evt_flags, int_reg};
  assign force_word  = {4'h0, force_reg, 1'b0};
  assign status_word = {8'h00, dir_sts_reg, sticky_sts, count_err_reg};

  // read mux; the clear register reads as zero
  // captured at the read commit
  always @* begin
    rd_data = {`AXI_DATA_W{1'b0}};
    if (addr_is(rd_addr, `OFF_IRQ_FLAG)) begin
      rd_data = {16'h0000, flag_word};
    end else if (addr_is(rd_addr, `OFF_IRQ_FORCE)) begin
      rd_data = {16'h0000, force_word};
    end else if (addr_is(rd_addr, `OFF_ENC_STATUS)) begin
      rd_data = {16'h0000, status_word};
    end
  end

endmodule // encoder_irq_clear_force_status

// >>> encoder_irq_clear_force_status_asserts.sv
// concurrent checks on the encoder interrupt block ports
`include "encoder_irq_consts.vh"
module encoder_irq_checker (
  input wire                   clk_sys,
  input wire                   rst_n,
  input wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire                   s_axi_awvalid,
  input wire                   s_axi_awready,
  input wire [`AXI_DATA_W-1:0] s_axi_wdata,
  input wire [3:0]             s_axi_wstrb,
  input wire                   s_axi_wvalid,
  input wire                   s_axi_wready,
  input wire [1:0]             s_axi_bresp,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_bready,
  input wire [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire [`AXI_DATA_W-1:0] s_axi_rdata,
  input wire                   s_axi_rvalid,
  input wire                   s_axi_rready,
  input wire                   irq_req,
  input wire                   irq_active
);
  logic       clr_take; // global clear write taken
  logic [3:0] clr_hist; // last four cycles of clear takes
  logic [5:0] rd_word;  // word index of the read under way
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  assign clr_take = s_axi_awvalid & s_axi_awready & (s_axi_awaddr[7:2] == 6'h01) & s_axi_wdata[0] & s_axi_wstrb[0];
  // history of clear writes, address of each read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clr_hist <= 4'h0;
      rd_word  <= 6'h00;
    end else begin
      clr_hist <= {clr_hist[2:0], clr_take};
      if (s_axi_arvalid && s_axi_arready) rd_word <= s_axi_araddr[7:2];
    end
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |-> ##2 s_axi_rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_force_rsvd: assert property (s_axi_rvalid && rd_word == 6'h02 |-> !s_axi_rdata[0] && s_axi_rdata[15:12] == 4'h0)
    else $error("force reserved bits not zero");
  a_status_rsvd: assert property (s_axi_rvalid && rd_word == 6'h03 |-> s_axi_rdata[15:8] == 8'h00)
    else $error("status upper byte not zero");
  a_req_marks_rise: assert property (irq_req == $rose(irq_active))
    else $error("request pulse apart from flag rise");
  a_clear_drops: assert property ($fell(irq_active) |-> clr_hist != 4'h0)
    else $error("global flag fell without a clear");
endmodule // encoder_irq_checker

bind encoder_irq_clear_force_status encoder_irq_checker u_checker (
  .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_active
);

// >>> test_encoder_irq_clear_force_status.sv
// self-checking testbench for the encoder interrupt block
`include "encoder_irq_consts.vh"
module test_encoder_irq_clear_force_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n;             // clock and reset
  logic [7:0]  s_axi_awaddr, s_axi_araddr; // bus addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;   // bus data
  logic [3:0]  s_axi_wstrb;                // byte lanes
  logic [1:0]  s_axi_bresp, s_axi_rresp;   // responses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] pls;                        // 11..1 events, 14..12 sticky sets, 15 index
  logic [15:0] irq_enable;                 // per-event enables
  logic [3:0]  lvl;                        // status levels, bits 7..4
  logic        idx_err;                    // error of last index transition
  logic        irq_req, irq_active;        // interrupt outputs
  logic [31:0] v, expv, d;                 // scratch values
  int          failures, num_checks, req_cnt, i;

  encoder_irq_clear_force_status u_dut (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .unit_timeout_evt(pls[11]), .index_latch_evt(pls[10]), .strobe_latch_evt(pls[9]), .compare_match_evt(pls[8]),
    .compare_ready_evt(pls[7]), .count_overflow_evt(pls[6]), .count_underflow_evt(pls[5]),
    .watchdog_expiry_evt(pls[4]), .direction_change_evt(pls[3]), .phase_error_evt(pls[2]),
    .count_error_evt(pls[1]), .irq_enable, .unit_position_seen(lvl[3]), .first_index_direction(lvl[2]),
    .current_direction(lvl[1]), .index_latched_direction(lvl[0]), .capture_overflow_pulse(pls[14]),
    .capture_direction_pulse(pls[13]), .first_index_pulse(pls[12]), .index_event_pulse(pls[15]),
    .index_count_error(idx_err), .irq_req, .irq_active
  );

  // clock, 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // count request pulses
  always @(posedge clk_sys) begin
    if (irq_req === 1'b1) req_cnt <= req_cnt + 1;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict;
  end

  task chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one write, response ready after a random stall
  task axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s, input logic [1:0] er);
    int n, dly;
    dly = $urandom % 4;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= wd;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; 1; n++) begin
      @(posedge clk_sys);
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (n >= dly) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // one read, data taken at the handshake edge
  task axi_rd(input logic [7:0] a, output logic [31:0] rd, input logic [1:0] er);
    int n, dly;
    dly = $urandom % 4;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; 1; n++) begin
      @(posedge clk_sys);
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (n >= dly) s_axi_rready <= 1'b1;
    end
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] rd;
    axi_rd(a, rd, `RESP_OKAY);
    chk(rd, want);
  endtask

  task pulse(input logic [15:0] p);
    pls <= p;
    @(posedge clk_sys);
    pls <= 16'h0000;
    @(posedge clk_sys);
  endtask

  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, pls, irq_enable, idx_err} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rst_n} = '0;
    {failures, num_checks, req_cnt} = '0;
    void'($urandom(32'h025177F4));
    lvl = 4'($urandom);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(`OFF_IRQ_FLAG, 32'h0);
    rd_chk(`OFF_IRQ_FORCE, 32'h0);
    rd_chk(`OFF_ENC_STATUS, {24'h0, lvl, 4'hE});
    rd_chk(`OFF_IRQ_CLEAR, 32'h0);
    // each event reaches its own flag and its own clear bit
    for (i = 1; i < 12; i++) begin
      pulse(16'h0001 << i);
      rd_chk(`OFF_IRQ_FLAG, 32'h1 << i);
      axi_wr(`OFF_IRQ_CLEAR, 32'h1 << i, 4'hF, `RESP_OKAY);
      rd_chk(`OFF_IRQ_FLAG, 32'h0);
    end
    // random clear masks, zeros keep
    pulse(16'h0FFE);
    expv = 32'h0FFE;
    repeat (6) begin
      v = $urandom & 32'h0000FFFE;
      axi_wr(`OFF_IRQ_CLEAR, v, 4'hF, `RESP_OKAY);
      expv = expv & ~v;
      rd_chk(`OFF_IRQ_FLAG, expv);
    end
    // random force patterns
    repeat (6) begin
      v = $urandom;
      axi_wr(`OFF_IRQ_FORCE, v, 4'hF, `RESP_OKAY);
      rd_chk(`OFF_IRQ_FORCE, v & 32'h0FFE);
      rd_chk(`OFF_IRQ_FLAG, (v | expv) & 32'h0FFE);
      axi_wr(`OFF_IRQ_CLEAR, 32'hFFFE, 4'h3, `RESP_OKAY);
      expv = 32'h0;
    end
    axi_wr(`OFF_IRQ_FORCE, 32'h0, 4'hF, `RESP_OKAY);
    axi_wr(`OFF_IRQ_FORCE, 32'h0F00, 4'h1, `RESP_OKAY);
    rd_chk(`OFF_IRQ_FLAG, 32'h0);
    // only direction change enabled into the global flag
    irq_enable <= 16'h0008;
    axi_wr(`OFF_IRQ_FORCE, 32'h0020, 4'hF, `RESP_OKAY);
    tick(4);
    chk(req_cnt, 0);
    pulse(16'h0008);
    tick(3);
    chk({31'h0, irq_active}, 32'h1);
    chk(req_cnt, 1);
    rd_chk(`OFF_IRQ_FLAG, 32'h0029);
    pulse(16'h0008);
    tick(3);
    chk(req_cnt, 1);
    axi_wr(`OFF_IRQ_CLEAR, 32'h1, 4'hF, `RESP_OKAY);
    tick(4);
    chk(req_cnt, 2);
    axi_wr(`OFF_IRQ_CLEAR, 32'h0029, 4'hF, `RESP_OKAY);
    tick(4);
    chk({31'h0, irq_active}, 32'h0);
    chk(req_cnt, 2);
    // sticky status bits and index error bit
    axi_wr(`OFF_ENC_STATUS, 32'hFFFF, 4'hF, `RESP_OKAY);
    rd_chk(`OFF_ENC_STATUS, {24'h0, lvl, 4'h0});
    pulse(16'h7000);
    rd_chk(`OFF_ENC_STATUS, {24'h0, lvl, 4'hE});
    axi_wr(`OFF_ENC_STATUS, 32'h4, 4'hF, `RESP_OKAY);
    rd_chk(`OFF_ENC_STATUS, {24'h0, lvl, 4'hA});
    idx_err <= 1'b1;
    pulse(16'h8000);
    idx_err <= 1'b0;
    rd_chk(`OFF_ENC_STATUS, {24'h0, lvl, 4'hB});
    pulse(16'h8000);
    rd_chk(`OFF_ENC_STATUS, {24'h0, lvl, 4'hA});
    // unmapped word and read-only flag register
    axi_wr(8'h10, 32'hFFFF, 4'hF, `RESP_SLVERR);
    axi_rd(8'h10, d, `RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(`OFF_IRQ_FLAG, 32'hFFFF, 4'hF, `RESP_OKAY);
    rd_chk(`OFF_IRQ_FLAG, 32'h0);
    // second reset clears force pattern
    axi_wr(`OFF_IRQ_FORCE, 32'h0FFE, 4'hF, `RESP_OKAY);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(`OFF_IRQ_FORCE, 32'h0);
    rd_chk(`OFF_IRQ_FLAG, 32'h0);
    print_verdict;
  end
endmodule // test_encoder_irq_clear_force_status
